// ===== inc/acc_alu_cfg.svh
// Constants for the 24-bit accumulator datapath.
`ifndef ACC_ALU_CFG_SVH
`define ACC_ALU_CFG_SVH
`define ACC_WORD_W 24
`define ACC_BITIDX_W 5
`define ACC_BITIDX_MAX 5'h17
`define ACC_OP_W 3
`define ACC_SEL_W 2
`define ACC_CYC_ABS 4'h2
`define ACC_CYC_ADD_REG 4'h1
`define ACC_CYC_ADD_IMM 4'h4
`define ACC_CYC_AND_REG 4'h3
`define ACC_CYC_AND_IMM 4'h6
`define ACC_CYC_BITCLR 4'h2
`define ACC_CYC_NVADD 4'h2
`define ACC_FLAGS_RESET 4'h0
`define ACC_FLAG_C 3
`define ACC_FLAG_O 2
`define ACC_FLAG_S 1
`define ACC_FLAG_Z 0
`endif

// ===== inc/acc_alu_pkg.sv
// Types shared by the accumulator datapath modules.
package acc_alu_pkg;
    typedef enum logic [2:0] {
        ACC_OP_ABS = 3'h0,
        ACC_OP_ADD = 3'h1,
        ACC_OP_AND = 3'h2,
        ACC_OP_BITCLR = 3'h3,
        ACC_OP_NVADD = 3'h4
    } acc_op_e;
    typedef enum logic [1:0] {
        ACC_SEL_X = 2'h0,
        ACC_SEL_Y = 2'h1,
        ACC_SEL_Z = 2'h2,
        ACC_SEL_R = 2'h3
    } acc_sel_e;
    typedef enum logic [3:0] {
        ACC_ST_IDLE = 4'h1,
        ACC_ST_WAIT = 4'h2,
        ACC_ST_NVWAIT = 4'h4,
        ACC_ST_DONE = 4'h8
    } acc_state_e;
endpackage

// ===== hdl/acc_adder.sv
// Combinational 24-bit two's complement adder with carry and overflow.
`timescale 1ns/1ps
`include "acc_alu_cfg.svh"
module acc_adder #(
    parameter int WIDTH = `ACC_WORD_W
) (
    // Operands.
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    // Result and flags.
    output logic [WIDTH-1:0] sum,
    output logic carry,
    output logic ovf
);
    logic [WIDTH:0] wide;

    // The extra bit holds the carry; the sum wraps modulo two to the width.
    always_comb begin
        wide = {1'b0, a} + {1'b0, b};
        sum = wide[WIDTH-1:0];
        carry = wide[WIDTH];
        ovf = (a[WIDTH-1] == b[WIDTH-1]) && (sum[WIDTH-1] != a[WIDTH-1]);
    end
endmodule

// ===== hdl/acc_logic.sv
// Combinational logic unit: absolute value, AND and single-bit clear.
`timescale 1ns/1ps
`include "acc_alu_cfg.svh"
module acc_logic #(
    parameter int WIDTH = `ACC_WORD_W
) (
    // Operands.
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    input wire logic [4:0] bit_idx,
    // Results.
    output logic [WIDTH-1:0] abs_res,
    output logic abs_carry,
    output logic abs_ovf,
    output logic [WIDTH-1:0] and_res,
    output logic [WIDTH-1:0] clr_res
);
    logic [WIDTH:0] neg;

    // Negation is done as invert plus one; the most negative value stays put and flags overflow.
    always_comb begin
        neg = {1'b0, ~a} + {{WIDTH{1'b0}}, 1'b1};
        if (a[WIDTH-1]) begin
            abs_res = neg[WIDTH-1:0];
            abs_carry = neg[WIDTH];
            abs_ovf = neg[WIDTH-1];
        end else begin
            abs_res = a;
            abs_carry = 1'b0;
            abs_ovf = 1'b0;
        end
        and_res = a & b;
        clr_res = a & ~(WIDTH'(1) << bit_idx);
    end
endmodule

// ===== hdl/acc_alu.sv
// Accumulator datapath with x, y, z and RAM-word accumulators and four flags.
`timescale 1ns/1ps
`include "acc_alu_cfg.svh"
// Summary of operation
// - All accumulators and RAM operands are 24 bits.
// - Operands and results are two's complement.
// - Result goes to first operand; second unchanged.
// - Pointed RAM word acts as accumulator r.
// - Each write updates its specified flags.
// - Abs: magnitude, four flags, two cycles.
// - Add register one cycle, immediate four.
// - Nonvolatile add to x, four flags, waits.
// - AND updates sign/zero; three or six cycles.
// - Bit clear index 0-23, sign/zero, two cycles.
// - Carry takes the addition carry out.
// - Sign follows result's top bit.
// - Overflow marks signed addition overflow.
module acc_alu #(
    parameter int WIDTH = `ACC_WORD_W
) (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RESET,
    // Instruction request from the sequencer.
    input wire logic START,
    input wire logic [2:0] OP,
    input wire logic [1:0] DST_SEL,
    input wire logic [1:0] SRC_SEL,
    input wire logic USE_IMM,
    input wire logic [WIDTH-1:0] IMM,
    input wire logic [4:0] BIT_IDX,
    // RAM word selected by the address pointer.
    input wire logic [WIDTH-1:0] RAM_RDATA,
    // Nonvolatile memory word fetch.
    input wire logic NV_VALID,
    input wire logic [WIDTH-1:0] NV_RDATA,
    // Status.
    output logic BUSY,
    output logic DONE,
    output logic NV_REQ,
    output logic RAM_WE,
    output logic [WIDTH-1:0] RAM_WDATA,
    output logic [WIDTH-1:0] ACC_X,
    output logic [WIDTH-1:0] ACC_Y,
    output logic [WIDTH-1:0] ACC_Z,
    output logic FLAG_CARRY,
    output logic FLAG_OVF,
    output logic FLAG_SIGN,
    output logic FLAG_ZERO
);
    // Only the documented word is served: the flag, clamp and RAM paths assume 24 bits.
    // A wider build would need a wider bit index as well, so it is refused outright.
    if (WIDTH != `ACC_WORD_W) begin : g_width_chk
        $error("acc_alu supports only the 24-bit word width");
    end

    // Sequencer state and cycle counter.
    acc_alu_pkg::acc_state_e state_q;
    logic [3:0] cnt_q;
    logic busy_q;
    logic take_d;
    // Architectural accumulators and the four flags.
    logic [WIDTH-1:0] x_q, y_q, z_q;
    logic [3:0] flags_q;
    // Instruction fields and operands latched at the take edge; the nonvolatile word lands in b_q later.
    logic [2:0] op_q;
    logic [1:0] dst_q;
    logic [WIDTH-1:0] a_q, b_q;
    logic [4:0] idx_q;
    // Result and flag candidates for the write-back edge.
    logic [WIDTH-1:0] res_d;
    logic c_d, o_d, upd_co_d;
    // Outputs of the two combinational units.
    logic [WIDTH-1:0] sum, abs_res, and_res, clr_res;
    logic add_c, add_o, abs_c, abs_o;
    // Registered handshake and RAM write outputs.
    logic done_q, nvreq_q, ramwe_q;
    logic [WIDTH-1:0] ramw_q;

    // Pick an accumulator; code 3 is the RAM word at the pointer.
    // Used for both the destination and the source, so the two decode alike and an
    // instruction may name the same accumulator twice.
    function automatic logic [WIDTH-1:0] pick(input logic [1:0] sel,
        input logic [WIDTH-1:0] x, input logic [WIDTH-1:0] y,
        input logic [WIDTH-1:0] z, input logic [WIDTH-1:0] r);
        case (sel)
            2'h0: pick = x;
            2'h1: pick = y;
            2'h2: pick = z;
            default: pick = r;
        endcase
    endfunction

    // Cycle count per instruction form.
    // The nonvolatile add has no entry of its own here; its length is set by the memory.
    function automatic logic [3:0] cycles(input logic [2:0] op, input logic imm);
        case (op)
            3'h0: cycles = `ACC_CYC_ABS;
            3'h1: cycles = imm ? `ACC_CYC_ADD_IMM : `ACC_CYC_ADD_REG;
            3'h2: cycles = imm ? `ACC_CYC_AND_IMM : `ACC_CYC_AND_REG;
            3'h3: cycles = `ACC_CYC_BITCLR;
            default: cycles = `ACC_CYC_NVADD;
        endcase
    endfunction

    // The nonvolatile add is decoded both by the sequencer and by the fetch request.
    function automatic logic is_nvadd(input logic [2:0] op);
        is_nvadd = (op == 3'h4);
    endfunction

    // A request is taken only from idle; a START held through a busy spell is ignored.
    assign take_d = START && (state_q == acc_alu_pkg::ACC_ST_IDLE);

    // Adder shared by both add forms and by the nonvolatile add.
    acc_adder #(.WIDTH(WIDTH)) u_add (
        .a(a_q),
        .b(b_q),
        .sum(sum),
        .carry(add_c),
        .ovf(add_o)
    );

    // Absolute value, AND and bit clear work on the same latched operands.
    acc_logic #(.WIDTH(WIDTH)) u_log (
        .a(a_q),
        .b(b_q),
        .bit_idx(idx_q),
        .abs_res(abs_res),
        .abs_carry(abs_c),
        .abs_ovf(abs_o),
        .and_res(and_res),
        .clr_res(clr_res)
    );

    // Result selection; only arithmetic touches carry and overflow.
    // Any opcode not decoded here falls through to the adder, so an unused code
    // behaves as an add rather than leaving the accumulator undefined.
    always_comb begin
        res_d = sum;
        c_d = add_c;
        o_d = add_o;
        upd_co_d = 1'b1;
        case (op_q)
            3'h0: begin
                res_d = abs_res;
                c_d = abs_c;
                o_d = abs_o;
            end
            3'h2: begin
                res_d = and_res;
                upd_co_d = 1'b0;
            end
            3'h3: begin
                res_d = clr_res;
                upd_co_d = 1'b0;
            end
            default: begin
                res_d = sum;
            end
        endcase
    end

    // Sequencer: latch operands, count cycles, wait for nonvolatile data.
    // Results land N edges after the take edge, N being the cycle count of the form.
    // A one-cycle add goes straight to the done state; longer forms count down in the
    // wait state first, which is why the counter is loaded with N - 1.
    // The nonvolatile add has no fixed length: a slow memory stalls the sequencer here,
    // and the flags keep the previous result until the fetched word has been added.
    // Operands other than the fetched word are latched at the take edge, so the sequencer may move the RAM pointer
    // or change its selects while an instruction is still running.
    // BUSY is kept in its own flop so the pin needs no decode of the state.
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            state_q <= acc_alu_pkg::ACC_ST_IDLE;
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            op_q <= 3'h0;
            dst_q <= 2'h0;
            a_q <= 24'h000000;
            b_q <= 24'h000000;
            idx_q <= 5'h00;
        end else begin
            case (state_q)
                acc_alu_pkg::ACC_ST_IDLE: begin
                    if (START) begin
                        busy_q <= 1'b1;
                        op_q <= OP;
                        // Clamp an index past the top so a stray code still clears a real bit.
                        idx_q <= (BIT_IDX > `ACC_BITIDX_MAX) ? `ACC_BITIDX_MAX : BIT_IDX;
                        if (is_nvadd(OP)) begin
                            dst_q <= 2'h0;
                            a_q <= x_q;
                            state_q <= acc_alu_pkg::ACC_ST_NVWAIT;
                        end else begin
                            dst_q <= DST_SEL;
                            // The RAM word is taken as it stands at the take edge.
                            a_q <= pick(DST_SEL, x_q, y_q, z_q, RAM_RDATA);
                            b_q <= USE_IMM ? IMM : pick(SRC_SEL, x_q, y_q, z_q, RAM_RDATA);
                            cnt_q <= cycles(OP, USE_IMM) - 4'h1;
                            state_q <= (cycles(OP, USE_IMM) == 4'h1) ?
                                acc_alu_pkg::ACC_ST_DONE : acc_alu_pkg::ACC_ST_WAIT;
                        end
                    end
                end
                acc_alu_pkg::ACC_ST_WAIT: begin
                    // Leave at one so the done state is the last counted cycle.
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        state_q <= acc_alu_pkg::ACC_ST_DONE;
                    end
                end
                acc_alu_pkg::ACC_ST_NVWAIT: begin
                    // Fetch time is set by the memory, so no fixed count applies.
                    // NV_RDATA is only looked at in the cycle that NV_VALID marks.
                    if (NV_VALID) begin
                        b_q <= NV_RDATA;
                        state_q <= acc_alu_pkg::ACC_ST_DONE;
                    end
                end
                acc_alu_pkg::ACC_ST_DONE: begin
                    state_q <= acc_alu_pkg::ACC_ST_IDLE;
                    busy_q <= 1'b0;
                end
                default: begin
                    state_q <= acc_alu_pkg::ACC_ST_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // Write-back into the destination accumulator on the final cycle.
    // The RAM word is not held here: it leaves as a one-cycle write strobe, the RAM
    // stores it at the pointer, and a later instruction reads it back from there.
    // Sums wider than the word simply lose their top bit, which only the carry keeps.
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            x_q <= 24'h000000;
            y_q <= 24'h000000;
            z_q <= 24'h000000;
            ramwe_q <= 1'b0;
            ramw_q <= 24'h000000;
        end else begin
            ramwe_q <= 1'b0;
            if (state_q == acc_alu_pkg::ACC_ST_DONE) begin
                case (dst_q)
                    2'h0: x_q <= res_d;
                    2'h1: y_q <= res_d;
                    2'h2: z_q <= res_d;
                    default: begin
                        ramwe_q <= 1'b1;
                        ramw_q <= res_d;
                    end
                endcase
            end
        end
    end

    // Flags follow the latest write; logic ops leave carry and overflow alone.
    // Zero is kept in positive sense: it is set when the written result is zero.
    // A fetch that never answers leaves every flag as the last write set it.
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            flags_q <= `ACC_FLAGS_RESET;
        end else if (state_q == acc_alu_pkg::ACC_ST_DONE) begin
            flags_q[`ACC_FLAG_S] <= res_d[WIDTH-1];
            flags_q[`ACC_FLAG_Z] <= (res_d == 24'h000000);
            if (upd_co_d) begin
                flags_q[`ACC_FLAG_C] <= c_d;
                flags_q[`ACC_FLAG_O] <= o_d;
            end
        end
    end

    // Registered handshake outputs.
    // DONE rises together with the fall of BUSY, so a new request may follow at once.
    // NV_REQ drops at the edge that takes the fetched word, so the memory sees one
    // request per fetch and can answer the next instruction afresh.
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            done_q <= 1'b0;
            nvreq_q <= 1'b0;
        end else begin
            done_q <= (state_q == acc_alu_pkg::ACC_ST_DONE);
            nvreq_q <= (take_d && is_nvadd(OP)) ||
                (state_q == acc_alu_pkg::ACC_ST_NVWAIT && !NV_VALID);
        end
    end

    // Outputs straight from flip-flops, with no gate between register and pin.
    assign BUSY = busy_q;
    assign DONE = done_q;
    assign NV_REQ = nvreq_q;
    assign RAM_WE = ramwe_q;
    assign RAM_WDATA = ramw_q;

    // Accumulators and flags as they stand after the latest write-back.
    assign ACC_X = x_q;
    assign ACC_Y = y_q;
    assign ACC_Z = z_q;
    assign FLAG_CARRY = flags_q[`ACC_FLAG_C];
    assign FLAG_OVF = flags_q[`ACC_FLAG_O];
    assign FLAG_SIGN = flags_q[`ACC_FLAG_S];
    assign FLAG_ZERO = flags_q[`ACC_FLAG_Z];
endmodule

// ===== tb/acc_alu_assertions.sv
// Port checker for the accumulator datapath, bound to its top module.
`timescale 1ns/1ps
module acc_alu_chk (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RESET,
    // Request side.
    input wire logic START,
    input wire logic [2:0] OP,
    input wire logic USE_IMM,
    input wire logic NV_VALID,
    // Status side.
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic NV_REQ,
    input wire logic FLAG_SIGN
);
    // A request counts only when the datapath is idle, so a START held while BUSY is high is not counted again.
    wire tk = START && !BUSY;
    wire ri = tk && !USE_IMM;
    wire im = tk && USE_IMM;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    abs_time_a:
    assert property (tk && OP == 3'h0 |=> BUSY[*2] ##1 (!BUSY && DONE)) else $error("abs time");
    add_reg_time_a:
    assert property (ri && OP == 3'h1 |=> BUSY ##1 (!BUSY && DONE)) else $error("add time");
    add_imm_time_a:
    assert property (im && OP == 3'h1 |=> BUSY[*4] ##1 (!BUSY && DONE)) else $error("addi time");
    and_reg_time_a:
    assert property (ri && OP == 3'h2 |=> BUSY[*3] ##1 (!BUSY && DONE)) else $error("and time");
    and_imm_time_a:
    assert property (im && OP == 3'h2 |=> BUSY[*6] ##1 (!BUSY && DONE)) else $error("andi time");
    bit_clr_time_a:
    assert property (tk && OP == 3'h3 |=> BUSY[*2] ##1 (!BUSY && DONE)) else $error("clr time");
    nv_fetch_a:
    assert property (tk && OP == 3'h4 |=> NV_REQ) else $error("no fetch request");
    nv_finish_a:
    assert property (NV_REQ && NV_VALID |-> ##[1:4] DONE) else $error("fetch not finished");
    flag_write_a:
    assert property ($changed(FLAG_SIGN) |-> $fell(BUSY)) else $error("flag moved off write");
endmodule
bind acc_alu acc_alu_chk u_chk (.MCLK(MCLK), .RESET(RESET), .START(START), .OP(OP),
    .USE_IMM(USE_IMM), .NV_VALID(NV_VALID), .BUSY(BUSY), .DONE(DONE), .NV_REQ(NV_REQ),
    .FLAG_SIGN(FLAG_SIGN));

// ===== tb/acc_mem_model.sv
// Sequencer-side memory model: pointed RAM word and slow nonvolatile fetch.
`timescale 1ns/1ps
module acc_mem_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // Datapath side.
    input wire logic ram_we,
    input wire logic [23:0] ram_wdata,
    input wire logic nv_req,
    output logic [23:0] ram_rdata,
    output logic nv_valid,
    output logic [23:0] nv_rdata,
    // Bench control.
    input wire logic [23:0] nv_word,
    input wire logic [3:0] nv_dly
);
    logic [3:0] cnt_q;
    // The pointed word takes every write-back.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ram_rdata <= 24'h0;
        end else if (ram_we) begin
            ram_rdata <= ram_wdata;
        end
    end
    // Fetch answers after nv_dly cycles; the data line toggles junk outside the pulse.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_q <= 4'h0;
            nv_valid <= 1'b0;
            nv_rdata <= 24'h0;
        end else begin
            nv_valid <= nv_req && !nv_valid && cnt_q == nv_dly;
            cnt_q <= (nv_req && !nv_valid) ? cnt_q + 4'h1 : 4'h0;
            nv_rdata <= (nv_req && cnt_q == nv_dly) ? nv_word : ~nv_rdata;
        end
    end
endmodule

// ===== tb/acc_alu_tb.sv
// Self-checking bench for the accumulator datapath.
`timescale 1ns/1ps
module acc_alu_tb;
    typedef struct packed {logic [3:0][23:0] m; logic [3:0] f; logic [3:0] lat; logic we;} acc_exp_s;
    logic mclk, reset, start, use_imm, busy, done, nv_req, ram_we, nv_valid;
    logic fc, fo, fs, fz;
    logic [2:0] op;
    logic [1:0] dst, src;
    logic [4:0] bit_idx;
    logic [3:0] nv_dly;
    logic [23:0] imm, ram_wdata, ax, ay, az, ram_rdata, nv_rdata, nv_word;
    logic [3:0][23:0] em = '0;
    logic [3:0] ef = 4'h0;
    acc_exp_s expq[$];
    acc_exp_s e;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    acc_alu u_dut (.MCLK(mclk), .RESET(reset), .START(start), .OP(op), .DST_SEL(dst),
        .SRC_SEL(src), .USE_IMM(use_imm), .IMM(imm), .BIT_IDX(bit_idx), .RAM_RDATA(ram_rdata),
        .NV_VALID(nv_valid), .NV_RDATA(nv_rdata), .BUSY(busy), .DONE(done), .NV_REQ(nv_req),
        .RAM_WE(ram_we), .RAM_WDATA(ram_wdata), .ACC_X(ax), .ACC_Y(ay), .ACC_Z(az),
        .FLAG_CARRY(fc), .FLAG_OVF(fo), .FLAG_SIGN(fs), .FLAG_ZERO(fz));
    acc_mem_model u_mem (.mclk(mclk), .reset(reset), .ram_we(ram_we), .ram_wdata(ram_wdata),
        .nv_req(nv_req), .ram_rdata(ram_rdata), .nv_valid(nv_valid), .nv_rdata(nv_rdata),
        .nv_word(nv_word), .nv_dly(nv_dly));
    // Free-running 200 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input string n, input logic [23:0] x, input logic [23:0] g);
        check_count++;
        if (g !== x) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic final_report();
        if (expq.size() != 0) chk("pending", 24'h0, 24'(expq.size()));
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Notes the expected outcome, then issues one instruction; h keeps START up one cycle past the take, with OP and IMM inverted.
    task automatic run(input logic [2:0] o, input logic [1:0] d, input logic [1:0] s,
                       input logic ui, input logic [23:0] iv, input logic [4:0] bi, input logic h);
        logic [23:0] a, b;
        logic [24:0] t;
        acc_exp_s x;
        if (o == 3'h4) d = 2'h0;
        a = em[d];
        b = (o == 3'h4) ? nv_word : (ui ? iv : em[s]);
        t = {1'b0, a} + {1'b0, b};
        case (o)
            3'h0: begin
                t = {1'b0, a[23] ? 24'h0 - a : a};
                ef[2] = a == 24'h800000;
                x.lat = 4'h2;
            end
            3'h2: begin
                t[23:0] = a & b;
                x.lat = ui ? 4'h6 : 4'h3;
            end
            3'h3: begin
                t[23:0] = a & ~(24'h1 << (bi > 5'h17 ? 5'h17 : bi));
                x.lat = 4'h2;
            end
            default: begin
                ef[2] = a[23] == b[23] && t[23] != a[23];
                x.lat = (o == 3'h4) ? 4'h0 : (ui ? 4'h4 : 4'h1);
            end
        endcase
        if (o != 3'h2 && o != 3'h3) ef[3] = t[24];
        ef[1] = t[23];
        ef[0] = t[23:0] == 24'h0;
        em[d] = t[23:0];
        x.m = em;
        x.f = ef;
        x.we = d == 2'h3;
        expq.push_back(x);
        {start, op, dst, src, use_imm, imm, bit_idx} <= {1'b1, o, d, s, ui, iv, bi};
        @(posedge mclk);
        if (h) begin
            op <= ~o;
            imm <= ~iv;
            @(posedge mclk);
        end
        start <= 1'b0;
        for (int k = 0; k < 40 && done !== 1'b1; k++) @(posedge mclk);
    endtask
    // Measures take-to-done cycles and compares each completion with the oldest note.
    always @(posedge mclk) begin
        cyc = (start === 1'b1 && busy === 1'b0) ? 0 : cyc + 1;
        if (done === 1'b1 && expq.size() == 0) begin
            chk("done_unasked", 24'h0, 24'h1);
        end else if (done === 1'b1) begin
            e = expq.pop_front();
            chk("acc_x", e.m[0], ax);
            chk("acc_y", e.m[1], ay);
            chk("acc_z", e.m[2], az);
            chk("ram_we", 24'(e.we), 24'(ram_we));
            if (e.we) chk("ram_wdata", e.m[3], ram_wdata);
            chk("flags", 24'(e.f), 24'({fc, fo, fs, fz}));
            if (e.lat != 4'h0) chk("cycles", 24'(e.lat), 24'(cyc - 1));
        end
    end
    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        final_report();
    end
    initial begin
        {start, op, dst, src, use_imm, imm, bit_idx} = '0;
        nv_word = 24'h0;
        nv_dly = 4'h1;
        reset = 1'b1;
        void'($urandom(32'habcb974f));
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        run(3'h1, 2'h0, 2'h0, 1'b1, 24'h7FFFFF, 5'h0, 1'b0);
        run(3'h1, 2'h0, 2'h0, 1'b1, 24'h000001, 5'h0, 1'b1);
        run(3'h0, 2'h0, 2'h0, 1'b0, 24'h0, 5'h0, 1'b0);
        run(3'h1, 2'h3, 2'h0, 1'b0, 24'h0, 5'h0, 1'b0);
        run(3'h1, 2'h3, 2'h0, 1'b0, 24'h0, 5'h0, 1'b1);
        run(3'h3, 2'h0, 2'h0, 1'b0, 24'h0, 5'h1F, 1'b0);
        repeat (300) begin
            nv_dly = 4'($urandom_range(1, 8));
            nv_word = 24'($urandom);
            run(3'($urandom_range(0, 4)), 2'($urandom), 2'($urandom), 1'($urandom),
                24'($urandom), 5'($urandom), 1'($urandom));
        end
        repeat (2) @(posedge mclk);
        final_report();
    end
endmodule
